// ==== slot_fifo_defines.svh ====
`ifndef SLOT_FIFO_DEFINES_SVH
`define SLOT_FIFO_DEFINES_SVH

`define SLOT_CFG_ADDR     8'h11
`define SLOT_CFG_RESET    16'h1000
`define FIRST_ON_BIT      0
`define FIRST_FMT_LSB     2
`define SECOND_ON_BIT     5
`define SECOND_FMT_LSB    6
`define OVF_GUARD_BIT     12
`define MAX_WORDS         8
`define WORD_IDX_W        3

`endif

// ==== slot_fifo_pkg.sv ====
package slot_fifo_pkg;

  typedef enum logic [2:0] {
    FMT_NONE  = 3'h0,
    FMT_W16   = 3'h1,
    FMT_W32   = 3'h2,
    FMT_PAIR16 = 3'h3,
    FMT_QUAD  = 3'h4,
    FMT_EXT32 = 3'h6
  } store_fmt_t;

  typedef logic [15:0] word_t;
  typedef logic [3:0]  word_cnt_t;

endpackage : slot_fifo_pkg

// ==== slot_word_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface slot_word_if;
  import slot_fifo_pkg::*;
  logic      load;
  word_t     words [8];
  word_cnt_t count;
  logic      busy;
  logic      valid;
  word_t     word;

  modport src (output load, output words, output count, input busy, input valid, input word);
  modport ser (input load, input words, input count, output busy, output valid, output word);
endinterface : slot_word_if

`default_nettype wire

// ==== slot_word_serializer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "slot_fifo_defines.svh"

module slot_word_serializer
  import slot_fifo_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // word burst
  slot_word_if.ser wb
);

  typedef enum logic [1:0] {
    S_IDLE = 2'b01,
    S_SEND = 2'b10
  } ser_state_t;

  ser_state_t state_q, state_d;
  word_t      words_q [8];
  word_t      words_d [8];
  word_cnt_t  cnt_q, cnt_d;
  word_cnt_t  idx_q, idx_d;
  logic       valid_q, valid_d;
  word_t      word_q, word_d;

  always_comb begin
    state_d = state_q;
    words_d = words_q;
    cnt_d   = cnt_q;
    idx_d   = idx_q;
    valid_d = 1'b0;
    word_d  = word_q;
    unique case (state_q)
      S_IDLE: begin
        if (wb.load && wb.count != 4'h0) begin
          words_d = wb.words;
          cnt_d   = wb.count;
          idx_d   = 4'h0;
          state_d = S_SEND;
        end
      end
      S_SEND: begin
        valid_d = 1'b1;
        word_d  = words_q[idx_q[`WORD_IDX_W-1:0]];
        idx_d   = idx_q + 4'h1;
        if (idx_q == cnt_q - 4'h1) begin
          state_d = S_IDLE;
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= S_IDLE;
      cnt_q   <= 4'h0;
      idx_q   <= 4'h0;
      valid_q <= 1'b0;
      word_q  <= 16'h0000;
      for (int i = 0; i < `MAX_WORDS; i++) begin
        words_q[i] <= 16'h0000;
      end
    end else begin
      state_q <= state_d;
      words_q <= words_d;
      cnt_q   <= cnt_d;
      idx_q   <= idx_d;
      valid_q <= valid_d;
      word_q  <= word_d;
    end
  end

  assign wb.busy  = (state_q == S_SEND);
  assign wb.valid = valid_q;
  assign wb.word  = word_q;

endmodule : slot_word_serializer

`default_nettype wire

// ==== slot_fifo_format_select.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "slot_fifo_defines.svh"

// Notes on behaviour
// (R1) format 0 writes nothing from that slot at its period end.
// (R2) format 1: one 16-bit word, sample if integrating else channel sum.
// (R3) format 2: one 32-bit word, sample if integrating else channel sum.
// (R4) format 3 while integrating: 16-bit sample then 16-bit background.
// (R5) format 4: 32-bit sample plus background, else four 16-bit channel words.
// (R6) format 6 not integrating: four 32-bit extended channel words.
// (R7) software programs only codes 0, 1, 2, 3, 4 or 6.
// (R8) software sets second format nonzero only with matching averaging or first off.
// (R9) bit 5 enables the second slot; resets to zero.
// (R10) bit 0 enables the first slot; resets to zero.
// (R11) first slot format lives in bits 4..2, reset zero.
// (R12) second slot format lives in bits 8..6, reset zero.
// (R13) guard bit 12 set: store only when not full; clear: overwrite.
// (R14) a disabled slot contributes no words whatever its format.
module slot_fifo_format_select
  import slot_fifo_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        soft_rst,
  // register port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  // slot results
  input  wire logic        first_done,
  input  wire logic        second_done,
  input  wire logic        dig_int_mode,
  input  wire logic [31:0] sample,
  input  wire logic [31:0] background,
  input  wire logic [31:0] chan_sum,
  input  wire logic [31:0] chan0,
  input  wire logic [31:0] chan1,
  input  wire logic [31:0] chan2,
  input  wire logic [31:0] chan3,
  // fifo write side
  input  wire logic        fifo_full,
  output logic             fifo_wr,
  output logic      [15:0] fifo_wdata,
  output logic             result_taken
);

  logic        rst;
  logic [15:0] cfg_q, cfg_d;
  logic [15:0] rdata_q, rdata_d;
  logic [1:0]  pend_q, pend_d;
  logic        first_on;
  logic        second_on;
  logic        store_overflow_guard;
  store_fmt_t  first_slot_store_format;
  store_fmt_t  second_slot_store_format;
  logic        sel_first;
  logic        sel_on;
  store_fmt_t  sel_fmt;
  word_t       words [8];
  word_cnt_t   cnt;
  logic [31:0] chans [4];
  logic        take;

  slot_word_if wb ();

  assign rst = sys_rst | soft_rst;

  assign first_on                 = cfg_q[`FIRST_ON_BIT];                          // R10
  assign second_on                = cfg_q[`SECOND_ON_BIT];                         // R9
  assign first_slot_store_format  = store_fmt_t'(cfg_q[`FIRST_FMT_LSB +: 3]);      // R11
  assign second_slot_store_format = store_fmt_t'(cfg_q[`SECOND_FMT_LSB +: 3]);     // R12
  assign store_overflow_guard     = cfg_q[`OVF_GUARD_BIT];

  // register file
  always_comb begin
    cfg_d   = cfg_q;
    rdata_d = 16'h0000;
    if (reg_wr && reg_addr == `SLOT_CFG_ADDR) begin
      cfg_d = reg_wdata;
    end
    if (reg_rd && reg_addr == `SLOT_CFG_ADDR) begin
      rdata_d = cfg_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_q   <= `SLOT_CFG_RESET;                                                  // R9 R10 R11 R12
      rdata_q <= 16'h0000;
    end else begin
      cfg_q   <= cfg_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // pending slot results, first slot served first; a new end wins over the clear
  assign sel_first = pend_q[0];
  assign sel_on    = sel_first ? first_on : second_on;
  assign sel_fmt   = sel_first ? first_slot_store_format : second_slot_store_format;
  assign take      = (pend_q != 2'b00) && !wb.busy;

  always_comb begin
    pend_d = pend_q;
    if (take) begin
      if (sel_first) begin
        pend_d[0] = 1'b0;
      end else begin
        pend_d[1] = 1'b0;
      end
    end
    if (first_done) begin
      pend_d[0] = 1'b1;
    end
    if (second_done) begin
      pend_d[1] = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pend_q <= 2'b00;
    end else begin
      pend_q <= pend_d;
    end
  end

  assign chans[0] = chan0;
  assign chans[1] = chan1;
  assign chans[2] = chan2;
  assign chans[3] = chan3;

  // word list for the selected slot; 32-bit values go high half first
  always_comb begin
    for (int i = 0; i < `MAX_WORDS; i++) begin
      words[i] = 16'h0000;
    end
    cnt = 4'h0;
    if (sel_on) begin                                                              // R14
      unique case (sel_fmt)
        FMT_NONE: cnt = 4'h0;                                                      // R1
        FMT_W16: begin                                                             // R2
          words[0] = dig_int_mode ? sample[15:0] : chan_sum[15:0];
          cnt      = 4'h1;
        end
        FMT_W32: begin                                                             // R3
          words[0] = dig_int_mode ? sample[31:16] : chan_sum[31:16];
          words[1] = dig_int_mode ? sample[15:0] : chan_sum[15:0];
          cnt      = 4'h2;
        end
        FMT_PAIR16: begin                                                          // R4
          if (dig_int_mode) begin
            words[0] = sample[15:0];
            words[1] = background[15:0];
            cnt      = 4'h2;
          end
        end
        FMT_QUAD: begin                                                            // R5
          cnt = 4'h4;
          if (dig_int_mode) begin
            words[0] = sample[31:16];
            words[1] = sample[15:0];
            words[2] = background[31:16];
            words[3] = background[15:0];
          end else begin
            for (int c = 0; c < 4; c++) begin
              words[c] = chans[c][15:0];
            end
          end
        end
        FMT_EXT32: begin                                                           // R6
          if (!dig_int_mode) begin
            for (int c = 0; c < 4; c++) begin
              words[2*c]   = chans[c][31:16];
              words[2*c+1] = chans[c][15:0];
            end
            cnt = 4'h8;
          end
        end
        default: cnt = 4'h0;
      endcase
    end
  end

  assign wb.load  = take;
  assign wb.words = words;
  assign wb.count = cnt;

  slot_word_serializer u_ser (
    .mclk    (mclk),
    .sys_rst (rst),
    .wb      (wb)
  );

  // with the guard clear the fifo wraps and drops its oldest word
  assign fifo_wr      = wb.valid && !(store_overflow_guard && fifo_full);          // R13
  assign fifo_wdata   = wb.word;
  assign result_taken = take;

  sequence s_burst8;
    wb.valid [*8];
  endsequence

  a_off_slot_silent: assert property (@(posedge mclk) disable iff (rst)
    take && !sel_on |-> cnt == 4'h0 ##1 !wb.busy)                                  // R14
    else $error("disabled slot produced words");
  a_none_no_words: assert property (@(posedge mclk) disable iff (rst)
    take && sel_fmt == FMT_NONE |=> !wb.busy ##1 !wb.valid)                        // R1
    else $error("format 0 produced words");
  a_fmt16_one_word: assert property (@(posedge mclk) disable iff (rst)
    take && sel_on && sel_fmt == FMT_W16 |-> cnt == 4'h1
      ##2 wb.valid && wb.word == $past(words[0], 2) ##1 !wb.valid)                 // R2
    else $error("format 1 word wrong");
  a_fmt32_two_words: assert property (@(posedge mclk) disable iff (rst)
    take && sel_on && sel_fmt == FMT_W32 |-> ##2 wb.valid [*2] ##1 !wb.valid)      // R3
    else $error("format 2 burst wrong");
  a_fmt3_pair_order: assert property (@(posedge mclk) disable iff (rst)
    take && sel_on && sel_fmt == FMT_PAIR16 && dig_int_mode
      |-> ##2 wb.valid && wb.word == $past(sample[15:0], 2)
      ##1 wb.valid && wb.word == $past(background[15:0], 3) ##1 !wb.valid)         // R4
    else $error("format 3 order wrong");
  a_fmt4_four_words: assert property (@(posedge mclk) disable iff (rst)
    take && sel_on && sel_fmt == FMT_QUAD |-> ##2 wb.valid [*4] ##1 !wb.valid)     // R5
    else $error("format 4 burst wrong");
  a_fmt6_eight_words: assert property (@(posedge mclk) disable iff (rst)
    take && sel_on && sel_fmt == FMT_EXT32 && !dig_int_mode
      |-> ##2 s_burst8 ##1 !wb.valid)                                              // R6
    else $error("format 6 burst wrong");
  a_guard_blocks_full: assert property (@(posedge mclk) disable iff (rst)
    store_overflow_guard && fifo_full |-> !fifo_wr)                                // R13
    else $error("write into full fifo under guard");
  a_wrap_writes_full: assert property (@(posedge mclk) disable iff (rst)
    !store_overflow_guard && wb.valid |-> fifo_wr)                                 // R13
    else $error("word dropped with guard clear");
  a_cfg_reset_value: assert property (@(posedge mclk)
    sys_rst |=> cfg_q == `SLOT_CFG_RESET && !first_on && !second_on)               // R9 R10 R11 R12
    else $error("config reset value wrong");

endmodule : slot_fifo_format_select

`default_nettype wire

// ==== word_sink_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// stands in for the word store behind the block; fullness is steered by the bench
module word_sink_model (
  // clock
  input  wire logic        mclk,
  // write side
  input  wire logic        fifo_wr,
  input  wire logic [15:0] fifo_wdata,
  // fullness control
  input  wire logic        full_set,
  output logic             fifo_full
);
  logic [15:0] got [$];

  assign fifo_full = full_set;

  // every strobed word is kept, full or not, as a wrapping store does
  always @(posedge mclk) begin
    if (fifo_wr === 1'b1) begin
      got.push_back(fifo_wdata);
    end
  end
endmodule : word_sink_model

`default_nettype wire

// ==== slot_fifo_format_select_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module slot_fifo_format_select_tb;
  import slot_fifo_pkg::*;
  logic        mclk         = 1'b0;
  logic        sys_rst      = 1'b1;
  logic        soft_rst     = 1'b0;
  logic        reg_wr       = 1'b0;
  logic        reg_rd       = 1'b0;
  logic [7:0]  reg_addr     = 8'h00;
  logic [15:0] reg_wdata    = 16'h0000;
  logic        first_done   = 1'b0;
  logic        second_done  = 1'b0;
  logic        dig_int_mode = 1'b0;
  logic [31:0] sample       = 32'hA001A002;
  logic [31:0] background   = 32'hB001B002;
  logic [31:0] chan_sum     = 32'hC001C002;
  logic [31:0] chan [4]     = '{32'hD001D002, 32'hD101D102, 32'hD201D202, 32'hD301D302};
  logic        full_set     = 1'b0;
  logic [2:0]  fmt_tab [6]  = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
  logic [15:0] reg_rdata;
  logic [15:0] fifo_wdata;
  logic        fifo_full;
  logic        fifo_wr;
  logic        result_taken;
  logic [15:0] cfg;
  word_t       exp_q [$];
  int          err_count    = 0;
  int          checks_done  = 0;

  slot_fifo_format_select slot_fifo_format_select_inst (
    .mclk, .sys_rst, .soft_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .first_done, .second_done, .dig_int_mode, .sample, .background, .chan_sum,
    .chan0(chan[0]), .chan1(chan[1]), .chan2(chan[2]), .chan3(chan[3]),
    .fifo_full, .fifo_wr, .fifo_wdata, .result_taken
  );

  word_sink_model word_sink_model_inst (
    .mclk, .fifo_wr, .fifo_wdata, .full_set, .fifo_full
  );

  initial begin
    forever #4 mclk = ~mclk;
  end

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    @(negedge mclk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask : reg_write

  // read data is registered, so it is looked at one cycle after the strobe
  task automatic reg_read(input logic [7:0] a, input logic [15:0] exp);
    @(negedge mclk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge mclk);
    reg_rd = 1'b0;
    chk(reg_rdata, exp);
    // read data stands for one cycle only, then drops back to zero
    @(negedge mclk);
    chk(reg_rdata, 16'h0000);
  endtask : reg_read

  function automatic void push32(input logic [31:0] x);
    exp_q.push_back(x[31:16]);
    exp_q.push_back(x[15:0]);
  endfunction : push32

  function automatic void expect_words(input logic [2:0] fmt, input logic integ);
    exp_q.delete();
    case (fmt)
      3'h1: exp_q.push_back(integ ? sample[15:0] : chan_sum[15:0]);
      3'h2: push32(integ ? sample : chan_sum);
      3'h3: if (integ) begin
        exp_q.push_back(sample[15:0]);
        exp_q.push_back(background[15:0]);
      end
      3'h4: if (integ) begin
        push32(sample);
        push32(background);
      end else begin
        for (int i = 0; i < 4; i++) exp_q.push_back(chan[i][15:0]);
      end
      3'h6: if (!integ) begin
        for (int i = 0; i < 4; i++) push32(chan[i]);
      end
      default: ;
    endcase
  endfunction : expect_words

  // slot period ends (bit 0 first, bit 1 second), then the words are gathered and compared
  task automatic run_slot(input logic [1:0] ends);
    int i;
    word_sink_model_inst.got.delete();
    @(negedge mclk);
    first_done = ends[0];
    second_done = ends[1];
    @(negedge mclk);
    first_done = 1'b0;
    second_done = 1'b0;
    for (i = 0; i < 20 && result_taken !== 1'b1; i++) @(negedge mclk);
    if (i == 20) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, 1'b0, 1'b1);
      finish_test();
    end
    repeat (12) @(negedge mclk);
    chk(16'(word_sink_model_inst.got.size()), 16'(exp_q.size()));
    for (i = 0; i < exp_q.size() && i < word_sink_model_inst.got.size(); i++) begin
      chk(word_sink_model_inst.got[i], exp_q[i]);
    end
  endtask : run_slot

  initial begin
    repeat (2) @(negedge mclk);
    sys_rst = 1'b0;
    reg_read(8'h11, 16'h1000);
    reg_read(8'h12, 16'h0000);
    reg_write(8'h11, 16'hFFFF);
    reg_read(8'h11, 16'hFFFF);
    @(negedge mclk);
    soft_rst = 1'b1;
    @(negedge mclk);
    soft_rst = 1'b0;
    reg_read(8'h11, 16'h1000);
    $display("test registers done");
    for (int s = 0; s < 2; s++) begin
      for (int m = 0; m < 2; m++) begin
        for (int k = 0; k < 6; k++) begin
          cfg = 16'h1000;
          // only legal codes, and only the slot under test is enabled, the other slot stays off
          if (s == 1) cfg[8:5] = {fmt_tab[k], 1'b1};
          else cfg[4:0] = {fmt_tab[k], 2'b01};
          dig_int_mode = m[0];
          reg_write(8'h11, cfg);
          expect_words(fmt_tab[k], m[0]);
          run_slot(s[0] ? 2'b10 : 2'b01);
        end
      end
    end
    $display("test formats done");
    dig_int_mode = 1'b1;
    reg_write(8'h11, 16'h1008);
    exp_q.delete();
    run_slot(2'b01);
    reg_write(8'h11, 16'h1080);
    run_slot(2'b10);
    $display("test disabled slots done");
    // both slots end together: first slot words leave before second slot words
    reg_write(8'h11, 16'h10A5);
    expect_words(3'h1, 1'b1);
    push32(sample);
    run_slot(2'b11);
    $display("test both slots done");
    full_set = 1'b1;
    reg_write(8'h11, 16'h1009);
    exp_q.delete();
    run_slot(2'b01);
    reg_write(8'h11, 16'h0009);
    expect_words(3'h2, 1'b1);
    run_slot(2'b01);
    full_set = 1'b0;
    $display("test overflow guard done");
    finish_test();
  end
endmodule : slot_fifo_format_select_tb

`default_nettype wire
